// >>> verilog/srx_regs.vh
// Purpose: Constants for the serial receiver status and wakeup block
// Assumes: Byte address of a register is four times its index
// Notes:   Definitions only; no logic lives here
`ifndef SRX_REGS_VH
`define SRX_REGS_VH

// ----------------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------------
`define SRX_IDX_CTRL1       8'h13
`define SRX_IDX_CTRL2       8'h14
`define SRX_IDX_CTRL3       8'h15
`define SRX_IDX_STAT1       8'h16
`define SRX_IDX_STAT2       8'h17
`define SRX_IDX_DATA        8'h18
`define SRX_IDX_BAUD        8'h19
`define SRX_IDX_BRKCTL      8'h1A

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SRX_C1_ENABLE       6
`define SRX_C1_LEN9         4
`define SRX_C1_WAKE_ADDR    3
`define SRX_C1_QUIET_SEL    2
`define SRX_C1_PAR_EN       1
`define SRX_C1_PAR_ODD      0
`define SRX_C2_FULL_IE      5
`define SRX_C2_QUIET_IE     4
`define SRX_C2_RX_EN        2
`define SRX_C2_STANDBY      1
`define SRX_C3_NINTH        7
`define SRX_ST_FULL         5
`define SRX_ST_QUIET        4
`define SRX_ST_OVR          3
`define SRX_ST_NOISE        2
`define SRX_ST_FRAME        1
`define SRX_ST_PAR          0
`define SRX_BRK_CLR_EN      7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SRX_RST_CTRL1       8'h00
`define SRX_RST_CTRL2       8'h00
`define SRX_RST_CTRL3       4'h0
`define SRX_RST_BAUD        8'h00
`define SRX_RST_BRKCTL      1'b0

// ----------------------------------------------------------------------
// Timing counts in oversample ticks; last bit index per frame length
// ----------------------------------------------------------------------
`define SRX_TICKS_PER_BIT   5'h10
`define SRX_QUIET_TICKS8    8'hA0
`define SRX_QUIET_TICKS9    8'hB0
`define SRX_LAST_IDX8       4'h9
`define SRX_LAST_IDX9       4'hA

`endif

// >>> verilog/srx_receiver.v
// Purpose: Receive status, error, wakeup and interrupt logic of a UART
// Assumes: rxd, stop_mode, wait_mode and debug_break are synchronous to pclk
// Notes:   APB slave with one wait-free access cycle; transmitter not included
`timescale 1ns/1ps
`include "srx_regs.vh"

// Contract
// - two or three bad stop samples set framing fault
// - break character sets framing fault
// - framing fault sets with buffer full
// - one stray stop sample: noise; more: framing
// - realign tick counter on falling edges
// - stop samples at ticks 8, 9, 10
// - standby suppresses all receiver interrupts
// - address mark clears standby
// - waking address character sets buffer full
// - idle character clears standby in idle mode
// - waking idle sets no flags
// - select selects where quiet counting starts
// - standby on quiet line may wake immediately
// - buffer transfer sets full, interrupt if enabled
// - ten or eleven ones set line quiet
// - overrun keeps old character, flags error
// - noise in any bit sets noise flag
// - enabled framing fault requests error interrupt
// - parity mismatch sets parity fault
// - wait mode keeps running, interrupts wake
// - stop mode halts, keeps registers, no wake
// - debug break protects flags unless clear enabled
// - oversample tick is sixteen times baud
// - length select frames eight or nine bits
module srx_receiver
(
  // APB clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Serial line and system state
  input  wire        rxd,
  input  wire        wait_mode,
  input  wire        stop_mode,
  input  wire        debug_break,
  // Requests
  output reg         rx_irq,
  output reg         err_irq,
  output reg         wake_req
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam [0:0] ST_HUNT = 1'b0;
  localparam [0:0] ST_RECV = 1'b1;

  reg  [7:0] first_control_reg;
  reg  [7:0] second_control_reg;
  reg  [3:0] third_control_reg;
  reg  [7:0] baud_div_reg;
  reg        break_clear_enable_reg;
  reg  [7:0] receive_buffer_reg;
  reg        ninth_bit_reg;
  reg  [5:0] status_reg;
  reg  [5:0] arm_mask_reg;
  reg  [7:0] div_cnt_reg;
  reg        state_reg;
  reg  [4:0] rt_cnt_reg;
  reg  [3:0] bit_idx_reg;
  reg  [1:0] ones_cnt_reg;
  reg        s3_reg;
  reg        s5_reg;
  reg        s8_reg;
  reg        s9_reg;
  reg        prev_s_reg;
  reg        last_bit_reg;
  reg  [8:0] shift_reg;
  reg        noise_acc_reg;
  reg  [7:0] quiet_cnt_reg;
  reg        quiet_armed_reg;

  wire       acc_done;
  wire       wr_done;
  wire       rd_done;
  wire [9:0] reg_idx;
  wire       brk_ok;
  wire       rx_run;
  wire       tick;
  wire       len9;
  wire       standby;
  wire       wake_addr;
  wire [3:0] last_idx;
  wire [7:0] quiet_thr;
  wire       s;
  wire       vote;
  wire       noisy;
  wire       stop_done;
  wire       start_hit;
  wire       quiet_count_en;
  wire       quiet_reach;
  wire       quiet_level;
  wire       addr_mark;
  wire       accept;
  wire       drop;
  wire       overrun;
  wire       par_err;
  wire       clr_now;
  wire       stat_rd;
  wire [5:0] set_vec;
  wire       sw_standby_wr;
  wire       hw_wake;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Two out of three vote
  function maj3;
    input a;
    input b;
    input c;
    begin
      maj3 = (a & b) | (a & c) | (b & c);
    end
  endfunction

  // Samples disagree
  function mixed3;
    input a;
    input b;
    input c;
    begin
      mixed3 = (a | b | c) & ~(a & b & c);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  assign acc_done = psel & penable & pready;
  assign wr_done  = acc_done & pwrite;
  assign rd_done  = acc_done & ~pwrite;
  assign reg_idx  = paddr[11:2];
  // Flags may only be touched outside a debug break, or when allowed
  assign brk_ok   = ~debug_break | break_clear_enable_reg;
  assign stat_rd  = rd_done & (reg_idx == {2'b00, `SRX_IDX_STAT1}) & brk_ok;
  assign clr_now  = rd_done & (reg_idx == {2'b00, `SRX_IDX_DATA}) & brk_ok;

  // ----------------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------------
  assign len9      = first_control_reg[`SRX_C1_LEN9];
  assign wake_addr = first_control_reg[`SRX_C1_WAKE_ADDR];
  assign standby   = second_control_reg[`SRX_C2_STANDBY];
  assign last_idx  = len9 ? `SRX_LAST_IDX9 : `SRX_LAST_IDX8;
  assign quiet_thr = len9 ? `SRX_QUIET_TICKS9 : `SRX_QUIET_TICKS8;
  // Stop mode halts everything on the serial side, registers keep state
  assign rx_run    = first_control_reg[`SRX_C1_ENABLE]
                   & second_control_reg[`SRX_C2_RX_EN] & ~stop_mode;

  // ----------------------------------------------------------------------
  // Oversample tick: one every baud_div+1 clocks, 16 per bit
  // ----------------------------------------------------------------------
  assign tick = rx_run & (div_cnt_reg == baud_div_reg);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt_reg <= 8'h00;
    else if (!rx_run || tick)
      div_cnt_reg <= 8'h00;
    else
      div_cnt_reg <= div_cnt_reg + 8'h01;
  end

  // ----------------------------------------------------------------------
  // Bit recovery
  // ----------------------------------------------------------------------
  assign s         = rxd;
  assign vote      = maj3(s8_reg, s9_reg, s);
  assign noisy     = mixed3(s8_reg, s9_reg, s);
  assign start_hit = tick & (state_reg == ST_HUNT) & ~s & (ones_cnt_reg == 2'h3);
  assign stop_done = tick & (state_reg == ST_RECV) & (rt_cnt_reg == 5'h0A)
                   & (bit_idx_reg == last_idx);

  // Character framing state machine, one step per tick
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg     <= ST_HUNT;
      rt_cnt_reg    <= 5'h01;
      bit_idx_reg   <= 4'h0;
      ones_cnt_reg  <= 2'h0;
      s3_reg        <= 1'b0;
      s5_reg        <= 1'b0;
      s8_reg        <= 1'b0;
      s9_reg        <= 1'b0;
      prev_s_reg    <= 1'b1;
      last_bit_reg  <= 1'b1;
      shift_reg     <= 9'h000;
      noise_acc_reg <= 1'b0;
    end
    else if (!rx_run && !stop_mode)
    begin
      // Receiver disabled: drop any partial character
      state_reg    <= ST_HUNT;
      ones_cnt_reg <= 2'h0;
    end
    else if (tick)
    begin
      prev_s_reg <= s;
      case (state_reg)
        ST_HUNT:
        begin
          // Start edge: a zero after three ones; this tick is RT1
          if (start_hit)
          begin
            state_reg     <= ST_RECV;
            rt_cnt_reg    <= 5'h02;
            bit_idx_reg   <= 4'h0;
            noise_acc_reg <= 1'b0;
            last_bit_reg  <= 1'b0;
          end
          else if (s)
            ones_cnt_reg <= (ones_cnt_reg == 2'h3) ? 2'h3 : ones_cnt_reg + 2'h1;
          else
            ones_cnt_reg <= 2'h0;
        end
        ST_RECV:
        begin
          if (rt_cnt_reg == 5'h03)
            s3_reg <= s;
          if (rt_cnt_reg == 5'h05)
            s5_reg <= s;
          if (rt_cnt_reg == 5'h08)
            s8_reg <= s;
          if (rt_cnt_reg == 5'h09)
            s9_reg <= s;
          // Falling edge after a one bit restarts the bit period
          if ((bit_idx_reg != 4'h0) && (rt_cnt_reg > 5'h0A) && prev_s_reg && !s
              && last_bit_reg)
          begin
            rt_cnt_reg  <= 5'h02;
            bit_idx_reg <= bit_idx_reg + 4'h1;
          end
          else if (rt_cnt_reg == `SRX_TICKS_PER_BIT)
          begin
            rt_cnt_reg  <= 5'h01;
            bit_idx_reg <= bit_idx_reg + 4'h1;
          end
          else
            rt_cnt_reg <= rt_cnt_reg + 5'h01;
          // Start verification at RT3, RT5, RT7
          if ((bit_idx_reg == 4'h0) && (rt_cnt_reg == 5'h07))
          begin
            if (maj3(s3_reg, s5_reg, s))
            begin
              state_reg    <= ST_HUNT;
              ones_cnt_reg <= 2'h0;
            end
            else if (s3_reg | s5_reg | s)
              noise_acc_reg <= 1'b1;
          end
          // Bit decision at RT10
          if (rt_cnt_reg == 5'h0A)
          begin
            if (bit_idx_reg == 4'h0)
            begin
              if (s8_reg | s9_reg | s)
                noise_acc_reg <= 1'b1;
            end
            else if (bit_idx_reg == last_idx)
            begin
              state_reg    <= ST_HUNT;
              ones_cnt_reg <= 2'h0;
            end
            else
            begin
              shift_reg    <= {vote, shift_reg[8:1]};
              last_bit_reg <= vote;
              if (noisy)
                noise_acc_reg <= 1'b1;
            end
          end
        end
        default:
          state_reg <= ST_HUNT;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Character completion
  // ----------------------------------------------------------------------
  // Eight-bit frames land in shift_reg[8:1]; bit 8 is always the top bit
  assign addr_mark = shift_reg[8];
  assign par_err   = first_control_reg[`SRX_C1_PAR_EN]
                   & ((len9 ? ^shift_reg : ^shift_reg[8:1])
                   ^ first_control_reg[`SRX_C1_PAR_ODD]);
  assign hw_wake   = stop_done & standby & wake_addr & addr_mark;
  assign drop      = stop_done & standby & ~hw_wake;
  assign overrun   = stop_done & ~drop & status_reg[`SRX_ST_FULL];
  assign accept    = stop_done & ~drop & ~status_reg[`SRX_ST_FULL];

  // Receive buffer and ninth bit; overrun leaves the old character
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      receive_buffer_reg <= 8'h00;
      ninth_bit_reg      <= 1'b0;
    end
    else if (accept)
    begin
      receive_buffer_reg <= len9 ? shift_reg[7:0] : shift_reg[8:1];
      ninth_bit_reg      <= shift_reg[8];
    end
  end

  // ----------------------------------------------------------------------
  // Quiet line detection
  // ----------------------------------------------------------------------
  // Select 1: count only after the stop bit; 0: from the first data bit
  assign quiet_count_en = s & ((state_reg == ST_HUNT)
                        | (~first_control_reg[`SRX_C1_QUIET_SEL]
                           & (bit_idx_reg != 4'h0)));
  assign quiet_level    = (quiet_cnt_reg == quiet_thr);
  assign quiet_reach    = tick & quiet_count_en
                        & (quiet_cnt_reg == quiet_thr - 8'h01);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      quiet_cnt_reg   <= 8'h00;
      quiet_armed_reg <= 1'b0;
    end
    else if (tick)
    begin
      if (start_hit || !quiet_count_en)
        quiet_cnt_reg <= 8'h00;
      else if (!quiet_level)
        quiet_cnt_reg <= quiet_cnt_reg + 8'h01;
      // Report only once per quiet period, after some traffic
      if (start_hit)
        quiet_armed_reg <= 1'b1;
      else if (quiet_reach)
        quiet_armed_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Status flags: hardware set wins over the two-step clear
  // ----------------------------------------------------------------------
  assign set_vec[`SRX_ST_FULL]  = accept;
  assign set_vec[`SRX_ST_QUIET] = quiet_reach & quiet_armed_reg & ~standby;
  assign set_vec[`SRX_ST_OVR]   = overrun;
  assign set_vec[`SRX_ST_NOISE] = accept & (noise_acc_reg | noisy);
  assign set_vec[`SRX_ST_FRAME] = accept & ~vote;
  assign set_vec[`SRX_ST_PAR]   = accept & par_err;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_reg   <= 6'h00;
      arm_mask_reg <= 6'h00;
    end
    else
    begin
      // During a protected break the arm survives and is finished later
      status_reg <= set_vec | (status_reg & ~(clr_now ? arm_mask_reg : 6'h00));
      if (stat_rd)
        arm_mask_reg <= status_reg;
      else if (clr_now)
        arm_mask_reg <= 6'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  assign sw_standby_wr = wr_done & (reg_idx == {2'b00, `SRX_IDX_CTRL2});

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_control_reg      <= `SRX_RST_CTRL1;
      second_control_reg     <= `SRX_RST_CTRL2;
      third_control_reg      <= `SRX_RST_CTRL3;
      baud_div_reg           <= `SRX_RST_BAUD;
      break_clear_enable_reg <= `SRX_RST_BRKCTL;
    end
    else
    begin
      if (wr_done && reg_idx == {2'b00, `SRX_IDX_CTRL1})
        first_control_reg <= pwdata[7:0];
      if (wr_done && reg_idx == {2'b00, `SRX_IDX_CTRL3})
        third_control_reg <= pwdata[3:0];
      if (wr_done && reg_idx == {2'b00, `SRX_IDX_BAUD})
        baud_div_reg <= pwdata[7:0];
      if (wr_done && reg_idx == {2'b00, `SRX_IDX_BRKCTL})
        break_clear_enable_reg <= pwdata[`SRX_BRK_CLR_EN];
      // Software write beats a same-cycle hardware wake
      if (sw_standby_wr)
        second_control_reg <= pwdata[7:0];
      else if (hw_wake || (standby && !wake_addr && quiet_level))
        second_control_reg[`SRX_C2_STANDBY] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // APB answer: data prepared in setup, ready in the first access cycle
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel && !penable)
      begin
        case (reg_idx)
          {2'b00, `SRX_IDX_CTRL1}:  prdata[7:0] <= first_control_reg;
          {2'b00, `SRX_IDX_CTRL2}:  prdata[7:0] <= second_control_reg;
          {2'b00, `SRX_IDX_CTRL3}:  prdata[7:0] <= {ninth_bit_reg, 3'b000,
                                                   third_control_reg};
          {2'b00, `SRX_IDX_STAT1}:  prdata[7:0] <= {2'b00, status_reg};
          {2'b00, `SRX_IDX_STAT2}:  prdata[7:0] <= 8'h00;
          {2'b00, `SRX_IDX_DATA}:   prdata[7:0] <= receive_buffer_reg;
          {2'b00, `SRX_IDX_BAUD}:   prdata[7:0] <= baud_div_reg;
          {2'b00, `SRX_IDX_BRKCTL}: prdata[7:0] <= {break_clear_enable_reg, 7'h00};
          default:                  pslverr     <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt requests; wake_req lets wait mode end, never stop mode
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_irq   <= 1'b0;
      err_irq  <= 1'b0;
      wake_req <= 1'b0;
    end
    else
    begin
      rx_irq   <= ~standby & ((status_reg[`SRX_ST_FULL]
                  & second_control_reg[`SRX_C2_FULL_IE])
                | (status_reg[`SRX_ST_QUIET]
                  & second_control_reg[`SRX_C2_QUIET_IE]));
      err_irq  <= ~standby & |(status_reg[3:0] & third_control_reg);
      wake_req <= wait_mode & ~stop_mode & (rx_irq | err_irq);
    end
  end

endmodule // srx_receiver

// >>> dv/srx_receiver_sva.sv
// Purpose: Port-level checks on the receiver status and wakeup block
// Assumes: Control writes are seen on the APB port and shadowed here
// Notes:   Standby cleared by hardware is not shadowed, so only enables are
`timescale 1ns/1ps
`include "srx_regs.vh"
module srx_receiver_sva
(
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  // System state and requests
  input wire        wait_mode,
  input wire        stop_mode,
  input wire        rx_irq,
  input wire        err_irq,
  input wire        wake_req
);
  // --------------------------------------------------------------
  // Shadow of the enable bits written by software
  // --------------------------------------------------------------
  logic [7:0] c1_sh;
  logic [7:0] c2_sh;
  logic [7:0] c3_sh;
  logic       wr_ok;
  logic       sby_wr;
  assign wr_ok  = psel & penable & pready & pwrite;
  assign sby_wr = wr_ok & (paddr[11:2] == {2'b00, `SRX_IDX_CTRL2}) & pwdata[`SRX_C2_STANDBY];
  // Writes land on the same edge as in the design
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      c1_sh <= 8'h00;
      c2_sh <= 8'h00;
      c3_sh <= 8'h00;
    end
    else if (wr_ok)
    begin
      if (paddr[11:2] == {2'b00, `SRX_IDX_CTRL1}) c1_sh <= pwdata[7:0];
      if (paddr[11:2] == {2'b00, `SRX_IDX_CTRL2}) c2_sh <= pwdata[7:0];
      if (paddr[11:2] == {2'b00, `SRX_IDX_CTRL3}) c3_sh <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // --------------------------------------------------------------
  // Requests
  // --------------------------------------------------------------
  AST_WAIT_WAKE: assert property (wait_mode && !stop_mode && (rx_irq || err_irq)
    |=> wake_req) else $error("wake request missing in wait mode");
  AST_WAKE_CAUSE: assert property (wake_req |-> $past(wait_mode)
    && $past(rx_irq || err_irq)) else $error("wake request without a cause");
  AST_STOP_NOWAKE: assert property (stop_mode |=> !wake_req)
    else $error("wake request in stop mode");
  AST_STOP_FREEZE: assert property (stop_mode && $past(stop_mode) && $past(stop_mode, 2)
    && !psel && !$past(psel) |=> $stable(rx_irq) && $stable(err_irq))
    else $error("requests changed in stop mode");
  AST_RX_GATE: assert property (rx_irq |->
    $past(c2_sh[`SRX_C2_FULL_IE] | c2_sh[`SRX_C2_QUIET_IE]))
    else $error("receive request with no enable");
  AST_ERR_GATE: assert property (err_irq |-> $past(|c3_sh[3:0]))
    else $error("error request with no enable");
  AST_STANDBY_MUTE: assert property (sby_wr && c1_sh[`SRX_C1_WAKE_ADDR]
    |=> ##1 !rx_irq && !err_irq) else $error("request active in standby");
  AST_ERR_HOLD: assert property ($fell(err_irq) |-> $past(psel) || $past(psel, 2))
    else $error("error request dropped without access");
  AST_RX_HOLD: assert property ($fell(rx_irq) |-> $past(psel) || $past(psel, 2))
    else $error("receive request dropped without access");
endmodule // srx_receiver_sva
bind srx_receiver srx_receiver_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .wait_mode(wait_mode), .stop_mode(stop_mode), .rx_irq(rx_irq), .err_irq(err_irq),
  .wake_req(wake_req));

// >>> dv/srx_tx_model.sv
// Purpose: Remote transmitter driving the serial input
// Assumes: Divisor 0, so one bit lasts 16 clocks
// Notes:   kind 0 good stop, 1 stop held low, 2 one low stop sample
`timescale 1ns/1ps
module srx_tx_model
(
  // Clock and line
  input  wire  pclk,
  output logic rxd
);
  // Idle line level is high
  initial rxd = 1'b1;
  // Frame: start, eight bits LSB first, stop; four idle clocks after
  task automatic send(input logic [7:0] d, input int kind);
    logic [9:0] fr;
    fr = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++)
      for (int c = 0; c < 16; c++)
      begin
        @(posedge pclk);
        if (i == 9 && (kind == 1 || (kind == 2 && c == 8))) rxd <= 1'b0;
        else rxd <= fr[i];
      end
    // Gap keeps four high ticks before the next start
    repeat (4) @(posedge pclk) rxd <= 1'b1;
  endtask
endmodule // srx_tx_model

// >>> dv/tb.sv
// Purpose: Self-checking bench for the receiver status and wakeup block
// Assumes: Zero-wait APB slave, divisor 0 gives a tick per clock
// Notes:   Status compares mask out flags that a scenario does not own
`timescale 1ns/1ps
`include "srx_regs.vh"
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd;
  logic        wait_mode, stop_mode, debug_break, rx_irq, err_irq, wake_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int          error_cnt = 0;
  int          compares  = 0;
  localparam logic [11:0] C1 = {2'b00, `SRX_IDX_CTRL1, 2'b00};
  localparam logic [11:0] C2 = {2'b00, `SRX_IDX_CTRL2, 2'b00};
  localparam logic [11:0] C3 = {2'b00, `SRX_IDX_CTRL3, 2'b00};
  localparam logic [11:0] S1 = {2'b00, `SRX_IDX_STAT1, 2'b00};
  localparam logic [11:0] DT = {2'b00, `SRX_IDX_DATA, 2'b00};
  localparam logic [11:0] BD = {2'b00, `SRX_IDX_BAUD, 2'b00};
  localparam logic [11:0] BK = {2'b00, `SRX_IDX_BRKCTL, 2'b00};
  srx_receiver i_srx_receiver (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .debug_break(debug_break), .rx_irq(rx_irq), .err_irq(err_irq), .wake_req(wake_req));
  srx_tx_model i_srx_tx_model (.pclk(pclk), .rxd(rxd));
  // 100 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task stop_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
           output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      error_cnt++;
      stop_test;
    end
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {24'h000000, d}, r, e);
  endtask
  task rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk(r & {24'h000000, m}, {24'h000000, x});
  endtask
  task tx(input logic [7:0] d, input int k);
    i_srx_tx_model.send(d, k);
  endtask
  // Bound on the whole run
  initial
  begin
    repeat (100000) @(posedge pclk);
    error_cnt++;
    stop_test;
  end
  initial
  begin : main
    logic [31:0] r;
    logic        e;
    logic [7:0]  pd [2] = '{8'h01, 8'h81};
    logic [7:0]  ps [2] = '{8'h21, 8'h20};
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h00000000; wait_mode = 1'b0; stop_mode = 1'b0; debug_break = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped place
    rd(C1, 8'hFF, `SRX_RST_CTRL1); rd(C2, 8'hFF, `SRX_RST_CTRL2); rd(S1, 8'h3F, 8'h00);
    rd(BK, 8'h80, 8'h00);
    apb(1'b0, 12'h000, 32'h00000000, r, e);
    chk({31'h0, e}, 32'h1); chk(r, 32'h0);
    wr(BD, 8'h00); wr(C3, 8'h0F); wr(C1, 8'h40); wr(C2, 8'h24); repeat (4) @(posedge pclk);
    // Good character, then bad stop and break
    tx(8'hA5, 0); rd(S1, 8'h2F, 8'h20); chk(rx_irq, 1'b1);
    rd(DT, 8'hFF, 8'hA5); rd(S1, 8'h2F, 8'h00);
    tx(8'h3C, 1); rd(S1, 8'h2F, 8'h22); chk(err_irq, 1'b1);
    rd(DT, 8'hFF, 8'h3C);
    tx(8'h00, 1); rd(S1, 8'h2F, 8'h22); rd(DT, 8'hFF, 8'h00);
    tx(8'h5A, 2); rd(S1, 8'h2F, 8'h24); rd(DT, 8'hFF, 8'h5A);
    tx(8'h11, 0); tx(8'h22, 0); rd(S1, 8'h2F, 8'h28); rd(DT, 8'hFF, 8'h11);
    // Stop mode: line ignored, registers kept, resumes after
    stop_mode <= 1'b1; tx(8'h77, 0); stop_mode <= 1'b0;
    rd(S1, 8'h2F, 8'h00); rd(C2, 8'hFF, 8'h24);
    tx(8'h66, 0); rd(S1, 8'h20, 8'h20);
    wait_mode <= 1'b1; repeat (2) @(posedge pclk); chk(wake_req, 1'b1);
    stop_mode <= 1'b1; repeat (2) @(posedge pclk); chk(wake_req, 1'b0);
    stop_mode <= 1'b0; wait_mode <= 1'b0;
    // Break with clear disabled: armed clear finishes afterwards
    rd(S1, 8'h20, 8'h20); debug_break <= 1'b1;
    rd(DT, 8'hFF, 8'h66); rd(S1, 8'h20, 8'h20); debug_break <= 1'b0;
    rd(DT, 8'hFF, 8'h66); rd(S1, 8'h20, 8'h00);
    wr(BK, 8'h80); tx(8'h44, 0); debug_break <= 1'b1;
    rd(S1, 8'h20, 8'h20); rd(DT, 8'hFF, 8'h44); rd(S1, 8'h20, 8'h00);
    debug_break <= 1'b0;
    // Even parity, good and bad
    wr(C1, 8'h42);
    for (int i = 0; i < 2; i++)
    begin
      tx(pd[i], 0); rd(S1, 8'h2F, ps[i]); rd(DT, 8'hFF, pd[i]);
    end
    // Address-mark wakeup, then back to standby by software
    wr(C1, 8'h48); wr(C2, 8'h26);
    tx(8'h12, 0); rd(S1, 8'h20, 8'h00); chk(rx_irq, 1'b0);
    tx(8'h92, 0); rd(C2, 8'hFF, 8'h24); rd(S1, 8'h20, 8'h20);
    wr(C2, 8'h26); repeat (2) @(posedge pclk); chk(rx_irq, 1'b0);
    rd(DT, 8'hFF, 8'h92);
    // Quiet line flag, idle wakeup without flags, instant wake
    wr(C1, 8'h40); wr(C2, 8'h34);
    tx(8'h55, 0); rd(S1, 8'h20, 8'h20); rd(DT, 8'hFF, 8'h55);
    repeat (200) @(posedge pclk); rd(S1, 8'h10, 8'h10); chk(rx_irq, 1'b1);
    rd(DT, 8'hFF, 8'h55); wr(C1, 8'h44); tx(8'hFF, 0);
    repeat (30) @(posedge pclk); rd(S1, 8'h30, 8'h20); rd(DT, 8'hFF, 8'hFF);
    tx(8'h33, 0); rd(S1, 8'h20, 8'h20); rd(DT, 8'hFF, 8'h33); wr(C2, 8'h36);
    repeat (200) @(posedge pclk); rd(C2, 8'hFF, 8'h34); rd(S1, 8'h30, 8'h00);
    wr(C2, 8'h36); rd(C2, 8'hFF, 8'h34);
    stop_test;
  end
endmodule // tb
